// *** host_model.sv ***
`timescale 1ns/1ns
`include "set_password_defs.vh"
module host_model (
  // bus clock
  input  wire         clock_i,
  // register port towards the handler
  output logic [3:0]  addr_o,
  output logic [15:0] wdata_o,
  output logic        wr_o,
  output logic        rd_o,
  input  wire  [15:0] rdata_i
);
  // idle bus from time zero
  initial {wr_o, rd_o, addr_o, wdata_o} = '0;

  // one assignment per edge, so back-to-back strobes never glitch
  task automatic acc(input logic w, r, input logic [3:0] a,
                     input logic [15:0] d);
    {wr_o, rd_o, addr_o, wdata_o} <= {w, r, a, d};
    @(posedge clock_i);
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    acc(1'b0, 1'b1, a, 16'h0000);
    {wr_o, rd_o} <= 2'b00;
    #1 d = rdata_i;
    @(posedge clock_i);
  endtask

  // command, then one whole sector
  task automatic set_pwd(input logic [15:0] ctl, rev);
    acc(1'b1, 1'b0, `REG_COMMAND, {8'h00, `CMD_SET_PASSWORD});
    for (int i = 0; i < 256; i++)
      acc(1'b1, 1'b0, `REG_DATA, i == 0 ? ctl : i == 17 ? rev :
          i < 17 ? {2{i[7:0]}} : 16'h0000);
    acc(1'b0, 1'b0, 4'h0, 16'h0000);
  endtask
endmodule // host_model

// *** security_set_password_handler.v ***
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`include "set_password_defs.vh"
module security_set_password_handler #(
  parameter WORDS = 256,
  parameter [15:0] REVISION_RESET = 16'hfffe
) (
  // clock and reset
  input  wire        clock_i,
  input  wire        arst_n_i,
  // power-on event seen by the security state
  input  wire        power_on_i,
  // register port
  input  wire [3:0]  addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [15:0] rdata_o,
  // security state outputs
  output reg         locked_o,
  output reg         master_unlock_ok_o,
  output reg         erase_only_o,
  output reg  [15:0] identify_word92_o,
  // interrupt
  output reg         irq_o
);

  // sequencer states; EXEC lasts exactly one cycle
  localparam ST_IDLE = 2'h0;
  localparam ST_DATA = 2'h1;
  localparam ST_EXEC = 2'h2;

  // decode shared by all register writes; reads go through the case mux
  function is_reg;
    input [3:0] a;
    input [3:0] r;
    begin
      is_reg = (a == r);
    end
  endfunction

  // status byte: ready always, request and error as asked
  // busy is never shown; the block never makes the host wait
  function [7:0] status_word;
    input drq;
    input err;
    begin
      status_word              = 8'h00;
      status_word[`ST_RDY_BIT] = 1'b1;
      status_word[`ST_DRQ_BIT] = drq;
      status_word[`ST_ERR_BIT] = err;
    end
  endfunction

  // error byte: abort alone, every other error bit clear
  function [7:0] error_word;
    input abort;
    begin
      error_word                 = 8'h00;
      error_word[`ERR_ABORT_BIT] = abort;
    end
  endfunction

  // sequencer and staged sector
  reg  [1:0]   state;
  reg  [7:0]   word_count;
  reg  [15:0]  control_word;
  reg  [15:0]  pwd_buf [0:15];
  reg  [15:0]  rev_buf;
  // stored passwords and revision code
  reg  [15:0]  user_pwd [0:15];
  reg  [15:0]  master_pwd [0:15];
  reg  [15:0]  master_rev;
  // task file bytes seen by the host
  reg  [7:0]   error_report;
  reg  [7:0]   completion_status;
  // lock state
  reg          sec_enabled;
  reg          sec_maximum;
  reg          frozen;
  // interrupt, spare register and read mux
  reg  [1:0]   irq_status;
  reg  [1:0]   irq_enable;
  reg  [3:0]   pwd_sel;
  reg  [15:0]  next_rdata;

  // decode of the command write and the data phase
  wire cmd_wr  = wr_i && is_reg(addr_i, `REG_COMMAND);
  wire data_wr = wr_i && is_reg(addr_i, `REG_DATA) && (state == ST_DATA);
  wire set_cmd = cmd_wr && (wdata_i[7:0] == `CMD_SET_PASSWORD);
  wire exec    = (state == ST_EXEC);
  wire ident_master = control_word[`CW_IDENT_BIT];
  wire level_max    = control_word[`CW_LEVEL_BIT];
  wire rev_valid = (rev_buf != `REV_NONE_LOW) &&
                   (rev_buf != `REV_NONE_HIGH);
  wire abort_evt = set_cmd && frozen;
  wire done_evt  = exec;
  wire [1:0] irq_evt = {abort_evt, done_evt};
  wire [7:0] next_wc = word_count + 8'h01;
  // clear and freeze strobes, accept and end of sector
  wire irq_clr_wr = wr_i && is_reg(addr_i, `REG_IRQ_CLEAR);
  wire freeze_cmd = cmd_wr && (wdata_i[7:0] == `CMD_FREEZE_LOCK);
  wire accept     = set_cmd && !frozen && (state == ST_IDLE);
  wire last_word  = (word_count == `WORD_LAST);

  // command sequencer: accept, take one sector, act on it
  // a refused command never leaves idle, so no data is asked for
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (set_cmd && !frozen) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          // a full sector is consumed before anything is stored
          if (data_wr && last_word) begin
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // word counter; restarts with every accepted command
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      word_count <= 8'h00;
    end else if (accept) begin
      word_count <= 8'h00;
    end else if (data_wr) begin
      word_count <= next_wc;
    end
  end

  // control word capture; identifier and level read from it
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      control_word <= 16'h0000;
    end else if (data_wr && word_count == `WORD_CONTROL) begin
      control_word <= wdata_i;
    end
  end

  // revision capture; used later only when master is chosen
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rev_buf <= 16'h0000;
    end else if (data_wr && word_count == `WORD_REVISION) begin
      rev_buf <= wdata_i;
    end
  end

  // password staging; words 1..16 kept whole, no trimming
  // stored copies drive no port here; the unlock path lives outside
  genvar g;
  generate
    // one slice per password word
    for (g = 0; g < 16; g = g + 1) begin : g_pwd
      // staging takes words 1..16 in order
      always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          pwd_buf[g] <= 16'h0000;
        end else if (data_wr && word_count == `WORD_PWD_FIRST + g) begin
          pwd_buf[g] <= wdata_i;
        end
      end
      // user copy; the master copy is kept untouched
      always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          user_pwd[g] <= 16'h0000;
        end else if (exec && !ident_master) begin
          user_pwd[g] <= pwd_buf[g];
        end
      end
      // master copy; lock enable is left alone
      always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          master_pwd[g] <= 16'h0000;
        end else if (exec && ident_master) begin
          master_pwd[g] <= pwd_buf[g];
        end
      end
    end
  endgenerate

  // lock enable and level; only a user set touches them
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sec_enabled <= 1'b0;
      sec_maximum <= 1'b0;
    end else if (exec && !ident_master) begin
      sec_enabled <= 1'b1;
      sec_maximum <= level_max;
    end
  end

  // revision code; master set only, reserved codes keep the old one
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      master_rev <= REVISION_RESET;
    end else if (exec && ident_master && rev_valid) begin
      master_rev <= rev_buf;
    end
  end

  // lock sampled at power-on only, so a set never locks at once
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      locked_o <= 1'b0;
    end else if (power_on_i) begin
      locked_o <= sec_enabled;
    end
  end

  // frozen until the next power-on; a freeze in that cycle wins
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frozen <= 1'b0;
    end else if (freeze_cmd) begin
      frozen <= 1'b1;
    end else if (power_on_i) begin
      frozen <= 1'b0;
    end
  end

  // master unlock refused once a maximum-level user set is made
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      master_unlock_ok_o <= 1'b1;
    end else begin
      master_unlock_ok_o <= !sec_maximum;
    end
  end

  // erase-only follows the lock one cycle later, at maximum level only
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      erase_only_o <= 1'b0;
    end else begin
      erase_only_o <= sec_maximum && locked_o;
    end
  end

  // identify word mirrors the stored revision code
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      identify_word92_o <= 16'h0000;
    end else begin
      identify_word92_o <= master_rev;
    end
  end

  // error byte; a new set-password command clears it, only a refusal sets abort
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      error_report <= 8'h00;
    end else if (abort_evt) begin
      error_report <= error_word(1'b1);
    end else if (set_cmd) begin
      error_report <= error_word(1'b0);
    end
  end

  // status byte; request stands through the whole data phase
  // a refusal outranks a plain accept of the same write
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      completion_status <= `STATUS_RESET;
    end else if (abort_evt) begin
      completion_status <= status_word(1'b0, 1'b1);
    end else if (set_cmd) begin
      completion_status <= status_word(1'b1, 1'b0);
    end else if (exec) begin
      completion_status <= status_word(1'b0, 1'b0);
    end
  end

  // sticky status: an event in the clearing cycle still lands
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_status <= 2'h0;
    end else if (irq_clr_wr) begin
      irq_status <= (irq_status & ~wdata_i[1:0]) | irq_evt;
    end else begin
      irq_status <= irq_status | irq_evt;
    end
  end

  // enable mask, same layout as the status bits
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_enable <= 2'h0;
    end else if (wr_i && is_reg(addr_i, `REG_IRQ_ENABLE)) begin
      irq_enable <= wdata_i[1:0];
    end
  end

  // spare selector, read back only; passwords are never readable
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwd_sel <= 4'h0;
    end else if (wr_i && is_reg(addr_i, `REG_PWD_SEL)) begin
      pwd_sel <= wdata_i[3:0];
    end
  end

  // level output from a flop; trails status by one cycle
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_enable);
    end
  end

  // read mux; unmapped and write-only offsets read as zero
  always @* begin
    next_rdata = 16'h0000;
    case (addr_i)
      `REG_ERROR:      next_rdata = {8'h00, error_report};
      `REG_STATUS:     next_rdata = {8'h00, completion_status};
      `REG_REVISION:   next_rdata = master_rev;
      `REG_SECURITY:   next_rdata = {11'h000, state != ST_IDLE, frozen,
                                     sec_maximum, locked_o, sec_enabled};
      `REG_IRQ_STATUS: next_rdata = {14'h0000, irq_status};
      `REG_IRQ_ENABLE: next_rdata = {14'h0000, irq_enable};
      `REG_PWD_SEL:    next_rdata = {12'h000, pwd_sel};
      // stored passwords stay write-only, so this word reads zero
      `REG_PWD_WORD:   next_rdata = 16'h0000;
      default:         next_rdata = 16'h0000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 16'h0000;
    end
  end

endmodule // security_set_password_handler

// *** security_set_password_handler_tb.sv ***
`timescale 1ns/1ns
`include "set_password_defs.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module security_set_password_handler_tb;
  logic        clock_i, arst_n_i, power_on_i, wr_i, rd_i;
  logic        locked_o, master_unlock_ok_o, erase_only_o, irq_o;
  logic [3:0]  addr_i;
  logic [15:0] wdata_i, rdata_o, identify_word92_o;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  security_set_password_handler security_set_password_handler_inst (
    .clock_i, .arst_n_i, .power_on_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .locked_o, .master_unlock_ok_o, .erase_only_o,
    .identify_word92_o, .irq_o);
  host_model host_inst (.clock_i, .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));

  // 100 ns clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    host_inst.rd(a, d);
    `CHK(d, e)
  endtask

  // bounded poll until neither busy nor requesting data
  task automatic done(input logic [15:0] st);
    logic [15:0] d;
    for (int i = 0; i < 20; i++) begin
      host_inst.rd(`REG_STATUS, d);
      if (d[`ST_BSY_BIT] === 1'b0 && d[`ST_DRQ_BIT] === 1'b0) break;
      if (i == 19) begin n_mismatch++; finish_test(); end
    end
    `CHK(d, st)
  endtask

  task automatic rst;
    arst_n_i = 1'b0;
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
  endtask

  task automatic pwr;
    @(posedge clock_i);
    power_on_i <= 1'b1;
    @(posedge clock_i);
    power_on_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
  endtask

  // main sequence
  initial begin
    power_on_i = 1'b0;
    rst();
    `CHK(identify_word92_o, 16'hfffe)
    host_inst.acc(1'b1, 1'b0, `REG_IRQ_ENABLE, 16'h0003);
    host_inst.set_pwd(16'h0101, 16'h1234);
    done(16'h0040);
    #1 `CHK({irq_o, identify_word92_o}, {1'b1, 16'h1234})
    rchk(`REG_IRQ_STATUS, 16'h0001);
    host_inst.acc(1'b1, 1'b0, `REG_IRQ_CLEAR, 16'h0001);
    rchk(`REG_SECURITY, 16'h0000);
    pwr();
    `CHK({irq_o, locked_o}, 2'b00)
    host_inst.set_pwd(16'h0001, 16'hffff);
    done(16'h0040);
    host_inst.set_pwd(16'h0000, 16'h5555);
    done(16'h0040);
    #1 `CHK({locked_o, identify_word92_o}, {1'b0, 16'h1234})
    rchk(`REG_SECURITY, 16'h0001);
    pwr();
    `CHK({locked_o, master_unlock_ok_o, erase_only_o}, 3'b110)
    rst();
    host_inst.acc(1'b1, 1'b0, `REG_COMMAND, {8'h00, `CMD_FREEZE_LOCK});
    host_inst.acc(1'b1, 1'b0, `REG_IRQ_ENABLE, 16'h0002);
    host_inst.acc(1'b1, 1'b0, `REG_COMMAND, {8'h00, `CMD_SET_PASSWORD});
    rchk(`REG_ERROR, 16'h0004);
    done(16'h0041);
    rchk(4'hf, 16'h0000);
    #1 `CHK(irq_o, 1'b1)
    host_inst.acc(1'b1, 1'b0, `REG_IRQ_CLEAR, 16'h0002);
    host_inst.acc(1'b0, 1'b0, 4'h0, 16'h0000);
    pwr();
    `CHK(irq_o, 1'b0)
    host_inst.set_pwd(16'h0100, 16'h7777);
    done(16'h0040);
    rchk(`REG_ERROR, 16'h0000);
    #1 `CHK({locked_o, master_unlock_ok_o}, 2'b00)
    pwr();
    `CHK({locked_o, erase_only_o}, 2'b11)
    rchk(`REG_SECURITY, 16'h0007);
    finish_test();
  end
endmodule // security_set_password_handler_tb

bind security_set_password_handler set_password_properties
  set_password_properties_inst (.clock_i, .arst_n_i, .power_on_i, .wr_i,
  .rd_i, .rdata_o, .locked_o, .master_unlock_ok_o, .erase_only_o,
  .identify_word92_o, .irq_o);

// *** set_password_defs.vh ***
`ifndef SET_PASSWORD_DEFS_VH
`define SET_PASSWORD_DEFS_VH
// command codes
`define CMD_SET_PASSWORD   8'hf1
`define CMD_FREEZE_LOCK    8'hf5
// register offsets
`define REG_ERROR          4'h1
`define REG_STATUS         4'h7
`define REG_COMMAND        4'h7
`define REG_DATA           4'h0
`define REG_REVISION       4'h8
`define REG_SECURITY       4'h9
`define REG_IRQ_STATUS     4'ha
`define REG_IRQ_ENABLE     4'hb
`define REG_IRQ_CLEAR      4'hc
`define REG_PWD_SEL        4'hd
`define REG_PWD_WORD       4'he
// error bits
`define ERR_ABORT_BIT      2
// status bits
`define ST_BSY_BIT         7
`define ST_RDY_BIT         6
`define ST_DRQ_BIT         3
`define ST_ERR_BIT         0
`define STATUS_RESET       8'h40
// control word fields
`define CW_IDENT_BIT       0
`define CW_LEVEL_BIT       8
// sector word indexes
`define WORD_CONTROL       8'h00
`define WORD_PWD_FIRST     8'h01
`define WORD_PWD_LAST      8'h10
`define WORD_REVISION      8'h11
`define WORD_LAST          8'hff
// revision code limits
`define REV_NONE_LOW       16'h0000
`define REV_NONE_HIGH      16'hffff
// security flags in security register
`define SEC_ENABLED_BIT    0
`define SEC_LOCKED_BIT     1
`define SEC_MAXIMUM_BIT    2
`define SEC_FROZEN_BIT     3
`define SEC_PENDING_BIT    4
// interrupt bits
`define IRQ_DONE_BIT       0
`define IRQ_ABORT_BIT      1
`endif

// *** set_password_properties.sv ***
`timescale 1ns/1ns
module set_password_properties (
  // clock and reset
  input wire        clock_i,
  input wire        arst_n_i,
  // watched ports
  input wire        power_on_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [15:0] rdata_o,
  input wire        locked_o,
  input wire        master_unlock_ok_o,
  input wire        erase_only_o,
  input wire [15:0] identify_word92_o,
  input wire        irq_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);

  // read data only in the cycle after a read strobe
  a_read_window: assert property (rdata_o != 16'h0000 |-> $past(rd_i))
    else $error("read data outside read window");
  // lock state moves only on a power-on event
  a_lock_power: assert property ($changed(locked_o) |-> $past(power_on_i))
    else $error("lock changed without power-on");
  a_erase_power: assert property ($rose(erase_only_o) |-> $past(power_on_i, 2))
    else $error("erase-only without power-on");
  a_erase_locked: assert property (erase_only_o |-> locked_o)
    else $error("erase-only while unlocked");
  a_erase_master: assert property (erase_only_o |-> !master_unlock_ok_o)
    else $error("master unlock allowed at maximum");
  a_rev_no_ffff: assert property (identify_word92_o != 16'hffff)
    else $error("revision ffff stored");
  // revision only follows a finished sector, not idle time
  a_rev_after_write: assert property ($changed(identify_word92_o) &&
    $past(identify_word92_o) != 16'h0000 |->
    $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3))
    else $error("revision changed without command");
  a_master_ok_drop: assert property ($fell(master_unlock_ok_o) |->
    $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3))
    else $error("master unlock dropped without command");
  a_irq_cause: assert property ($rose(irq_o) |-> $past(wr_i) ||
    $past(wr_i, 2) || $past(wr_i, 3) || $past(wr_i, 4))
    else $error("interrupt without cause");
  c_lock: cover property (power_on_i ##1 locked_o);
  c_erase: cover property ($rose(erase_only_o));
  c_irq: cover property ($rose(irq_o));
endmodule // set_password_properties
